// ===== frame_policy_pkg.sv
`default_nettype none
package frame_policy_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTL_A = 8'h03;
  localparam logic [7:0] ADDR_CTL_B = 8'h04;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ----------------------------------------
  // Control A fields
  // ----------------------------------------
  localparam int A_PASS_ALL = 7;
  localparam int A_REPEATER = 6;
  localparam int A_TX_FC = 5;
  localparam int A_RX_FC = 4;
  localparam int A_LEN_CHK = 3;
  localparam int A_AGING = 2;
  localparam int A_FAST_AGE = 1;
  localparam int A_AGGR_BACKOFF = 0;

  // ----------------------------------------
  // Control B fields
  // ----------------------------------------
  localparam int B_VLAN_DISCARD = 7;
  localparam int B_MC_STORM_DIS = 6;
  localparam int B_BP_CARRIER = 5;
  localparam int B_FAIR = 4;
  localparam int B_NO_EXC_DROP = 3;
  localparam int B_HUGE = 2;
  localparam int B_LEGAL_MAX = 1;
  localparam int B_PRIO_RESERVE = 0;

  // Strap-loaded bits are zero here until captured
  localparam logic [7:0] CTL_A_RST = 8'h34;
  localparam logic [7:0] CTL_B_RST = 8'hf1;

  // ----------------------------------------
  // Frame limits
  // ----------------------------------------
  localparam logic [15:0] LEN_TYPE_MAX = 16'h05dc;
  localparam logic [10:0] LEN_HUGE = 11'h77c;
  localparam logic [10:0] LEN_PLAIN = 11'h600;
  localparam logic [10:0] LEN_TAGGED = 11'h5f2;
  localparam logic [10:0] LEN_UNTAGGED = 11'h5ee;
  localparam logic [4:0] EXC_COLLISIONS = 5'h10;
  localparam logic [5:0] HP_RESERVE_BUFS = 6'h30;
  localparam logic [5:0] HP_RESERVE_NONE = 6'h00;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam longint unsigned CLK_PERIOD_NS = 25;
  localparam longint unsigned FAST_AGE_US = 800;
  localparam longint unsigned FAST_AGE_CYC = FAST_AGE_US * 1000 / CLK_PERIOD_NS;
  localparam longint unsigned NORM_AGE_S = 200;
  localparam longint unsigned NORM_AGE_CYC = NORM_AGE_S * 64'd1000000000 / CLK_PERIOD_NS;
  localparam int AGE_CNT_W = 33;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
endpackage : frame_policy_pkg
`default_nettype wire

// ===== age_if.sv
`default_nettype none
interface age_if;
  logic enable;
  logic fast;
  logic tick;
  modport ctl (output enable, output fast, input tick);
  modport timer (input enable, input fast, output tick);
endinterface : age_if
`default_nettype wire

// ===== age_timer.sv
`default_nettype none
module age_timer
  import frame_policy_pkg::*;
#(
  parameter logic [AGE_CNT_W-1:0] FAST_CYCLES = AGE_CNT_W'(FAST_AGE_CYC),
  parameter logic [AGE_CNT_W-1:0] NORM_CYCLES = AGE_CNT_W'(NORM_AGE_CYC)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control from the register bank
  age_if.timer ai
);
  logic [AGE_CNT_W-1:0] cnt_r;
  logic [AGE_CNT_W-1:0] cnt_nxt;
  logic [AGE_CNT_W-1:0] period;
  logic wrap;
  logic tick_r;

  // Switching to fast mid-period wraps at once if the count has reached FAST_CYCLES - 1, never waits out the slow count
  assign period = ai.fast ? FAST_CYCLES : NORM_CYCLES;
  assign wrap = cnt_r >= period - 1'b1;
  assign cnt_nxt = (!ai.enable || wrap) ? '0 : cnt_r + 1'b1;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= ai.enable && wrap;
    end
  end

  assign ai.tick = tick_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_fast_bound;
    $past(ai.fast) && ai.fast |-> cnt_r < FAST_CYCLES;
  endproperty
  a_fast_bound: assert property (p_fast_bound) else $error("fast age count overran");

  property p_age_off;
    !ai.enable |=> !tick_r;
  endproperty
  a_age_off: assert property (p_age_off) else $error("age tick while aging off");
endmodule : age_timer
`default_nettype wire

// ===== switch_global_frame_policy.sv
`default_nettype none
module switch_global_frame_policy
  import frame_policy_pkg::*;
#(
  parameter logic [AGE_CNT_W-1:0] FAST_AGE_CYCLES = AGE_CNT_W'(FAST_AGE_CYC),
  parameter logic [AGE_CNT_W-1:0] NORM_AGE_CYCLES = AGE_CNT_W'(NORM_AGE_CYC)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Strap pins
  input wire logic strap_pin_backoff_collision,
  input wire logic strap_pin_max_length,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Frame attributes
  input wire logic sniffer_active,
  input wire logic frame_start,
  input wire logic frame_done,
  input wire logic frame_bad,
  input wire logic frame_tagged,
  input wire logic [10:0] frame_len,
  input wire logic [15:0] len_type,
  input wire logic [10:0] payload_len,
  input wire logic [4:0] collisions,
  input wire logic vlan_cross,
  input wire logic known_ucast,
  // Flow control and forwarding events
  input wire logic pause_req,
  input wire logic rx_pause_frame,
  input wire logic fc_contention,
  input wire logic dest_all_ones,
  input wire logic dest_mcast,
  input wire logic mirror_req,
  // Verdicts
  output logic verdict_valid,
  output logic frame_drop,
  output logic pause_send,
  output logic pause_honor,
  output logic drop_nonfc,
  output logic throttle_fc,
  output logic storm_count,
  output logic mirror_allow,
  // Policy levels
  output logic hub_mode,
  output logic aggressive_backoff,
  output logic carrier_backpressure,
  output logic aging_on,
  output logic age_tick,
  output logic [5:0] hp_reserve
);
  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  logic [1:0] bo_sync_r;
  logic [1:0] ml_sync_r;
  logic [1:0] strap_cnt_r;
  logic strap_done_r;
  logic strap_take;

  // Pins settle through the synchroniser before being loaded
  assign strap_take = !strap_done_r && strap_cnt_r == STRAP_SETTLE;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bo_sync_r <= 2'h0;
      ml_sync_r <= 2'h0;
      strap_cnt_r <= 2'h0;
      strap_done_r <= 1'b0;
    end else begin
      bo_sync_r <= {bo_sync_r[0], strap_pin_backoff_collision};
      ml_sync_r <= {ml_sync_r[0], strap_pin_max_length};
      strap_cnt_r <= strap_done_r ? strap_cnt_r : strap_cnt_r + 2'h1;
      strap_done_r <= strap_done_r || strap_take;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [7:0] ctl_a_r;
  logic [7:0] ctl_b_r;
  logic [7:0] ctl_a_nxt;
  logic [7:0] ctl_b_nxt;
  logic wr_a;
  logic wr_b;
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic rvalid_r;

  assign wr_a = reg_wr && reg_addr == ADDR_CTL_A;
  assign wr_b = reg_wr && reg_addr == ADDR_CTL_B;

  // Strap load wins over a write in the same cycle
  always_comb begin
    ctl_a_nxt = wr_a ? reg_wdata : ctl_a_r;
    ctl_b_nxt = wr_b ? reg_wdata : ctl_b_r;
    if (strap_take) begin
      ctl_a_nxt[A_AGGR_BACKOFF] = bo_sync_r[1];
      ctl_b_nxt[B_NO_EXC_DROP] = bo_sync_r[1];
      ctl_b_nxt[B_LEGAL_MAX] = ml_sync_r[1];
    end
  end

  assign rdata_nxt = (reg_addr == ADDR_CTL_A) ? ctl_a_r :
                     (reg_addr == ADDR_CTL_B) ? ctl_b_r : RD_UNMAPPED;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_a_r <= CTL_A_RST;
      ctl_b_r <= CTL_B_RST;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      ctl_a_r <= ctl_a_nxt;
      ctl_b_r <= ctl_b_nxt;
      rdata_r <= reg_rd ? rdata_nxt : rdata_r;
      rvalid_r <= reg_rd;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;

  // ----------------------------------------
  // Per-frame verdict
  // ----------------------------------------
  logic [7:0] snap_a_r;
  logic [7:0] snap_b_r;
  logic [10:0] limit;
  logic pass_all;
  logic len_drop;
  logic size_drop;
  logic col_drop;
  logic vlan_drop;
  logic drop_w;
  logic verdict_valid_r;
  logic frame_drop_r;

  // Frames already in flight keep the settings they started with
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      snap_a_r <= CTL_A_RST;
      snap_b_r <= CTL_B_RST;
    end else if (frame_start) begin
      snap_a_r <= ctl_a_r;
      snap_b_r <= ctl_b_r;
    end
  end

  assign limit = snap_b_r[B_HUGE] ? LEN_HUGE :
                 !snap_b_r[B_LEGAL_MAX] ? LEN_PLAIN :
                 frame_tagged ? LEN_TAGGED : LEN_UNTAGGED;
  assign pass_all = snap_a_r[A_PASS_ALL] && sniffer_active;
  assign len_drop = snap_a_r[A_LEN_CHK] && len_type < LEN_TYPE_MAX
                    && len_type != {5'h00, payload_len};
  assign size_drop = frame_len > limit;
  assign col_drop = collisions >= EXC_COLLISIONS && !snap_b_r[B_NO_EXC_DROP];
  assign vlan_drop = vlan_cross && (snap_b_r[B_VLAN_DISCARD] || !known_ucast);
  // Debug pass-all overrides every drop cause
  assign drop_w = !pass_all
                  && (frame_bad || len_drop || size_drop || col_drop || vlan_drop);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      verdict_valid_r <= 1'b0;
      frame_drop_r <= 1'b0;
    end else begin
      verdict_valid_r <= frame_done;
      frame_drop_r <= frame_done && drop_w;
    end
  end

  assign verdict_valid = verdict_valid_r;
  assign frame_drop = frame_drop_r;

  // ----------------------------------------
  // Flow control and forwarding decisions
  // ----------------------------------------
  logic pause_send_r;
  logic pause_honor_r;
  logic drop_nonfc_r;
  logic throttle_fc_r;
  logic storm_count_r;
  logic mirror_allow_r;
  logic [5:0] hp_reserve_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pause_send_r <= 1'b0;
      pause_honor_r <= 1'b0;
      drop_nonfc_r <= 1'b0;
      throttle_fc_r <= 1'b0;
      storm_count_r <= 1'b0;
      mirror_allow_r <= 1'b0;
      hp_reserve_r <= HP_RESERVE_NONE;
    end else begin
      pause_send_r <= pause_req && ctl_a_r[A_TX_FC];
      pause_honor_r <= rx_pause_frame && ctl_a_r[A_RX_FC];
      drop_nonfc_r <= fc_contention && ctl_b_r[B_FAIR];
      throttle_fc_r <= fc_contention && !ctl_b_r[B_FAIR];
      storm_count_r <= dest_all_ones
                       || (dest_mcast && !ctl_b_r[B_MC_STORM_DIS]);
      mirror_allow_r <= mirror_req && ctl_b_r[B_VLAN_DISCARD];
      hp_reserve_r <= ctl_b_r[B_PRIO_RESERVE] ? HP_RESERVE_BUFS : HP_RESERVE_NONE;
    end
  end

  assign pause_send = pause_send_r;
  assign pause_honor = pause_honor_r;
  assign drop_nonfc = drop_nonfc_r;
  assign throttle_fc = throttle_fc_r;
  assign storm_count = storm_count_r;
  assign mirror_allow = mirror_allow_r;
  assign hp_reserve = hp_reserve_r;

  // ----------------------------------------
  // Policy levels and aging
  // ----------------------------------------
  age_if ag ();

  assign ag.enable = ctl_a_r[A_AGING];
  assign ag.fast = ctl_a_r[A_FAST_AGE];

  age_timer #(
    .FAST_CYCLES(FAST_AGE_CYCLES),
    .NORM_CYCLES(NORM_AGE_CYCLES)
  ) u_age (
    .clk(clk),
    .rst(rst),
    .ai(ag.timer)
  );

  assign age_tick = ag.tick;
  assign hub_mode = ctl_a_r[A_REPEATER];
  assign aggressive_backoff = ctl_a_r[A_AGGR_BACKOFF];
  assign carrier_backpressure = ctl_b_r[B_BP_CARRIER];
  assign aging_on = ctl_a_r[A_AGING];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_hub_write;
    wr_a && !strap_take |=> hub_mode == $past(reg_wdata[A_REPEATER]);
  endproperty
  a_hub_write: assert property (p_hub_write) else $error("hub mode not written");

  property p_no_pause;
    !ctl_a_r[A_TX_FC] |=> !pause_send;
  endproperty
  a_no_pause: assert property (p_no_pause) else $error("pause sent while disabled");

  property p_honor;
    rx_pause_frame |=> pause_honor == $past(ctl_a_r[A_RX_FC]);
  endproperty
  a_honor: assert property (p_honor) else $error("pause honour wrong");

  property p_strap;
    $rose(strap_done_r) |-> aggressive_backoff == $past(bo_sync_r[1])
                            && ctl_b_r[B_LEGAL_MAX] == $past(ml_sync_r[1]);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not captured");

  property p_size;
    frame_done && !pass_all && frame_len > limit |=> frame_drop;
  endproperty
  a_size: assert property (p_size) else $error("oversize frame kept");

  property p_huge_keep;
    frame_done && snap_b_r[B_HUGE] && frame_len <= LEN_HUGE && !frame_bad && !len_drop
    && !col_drop && !vlan_drop |=> verdict_valid && !frame_drop;
  endproperty
  a_huge_keep: assert property (p_huge_keep) else $error("huge frame dropped");

  property p_excess;
    frame_done && !pass_all && collisions >= EXC_COLLISIONS
    && !snap_b_r[B_NO_EXC_DROP] |=> frame_drop;
  endproperty
  a_excess: assert property (p_excess) else $error("collided frame kept");

  property p_mirror;
    mirror_allow |-> $past(ctl_b_r[B_VLAN_DISCARD]);
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror while discard off");

  property p_fair;
    fc_contention |=> drop_nonfc != throttle_fc;
  endproperty
  a_fair: assert property (p_fair) else $error("fair mode split wrong");

  property p_snapshot;
    frame_start |=> snap_a_r == $past(ctl_a_r) && snap_b_r == $past(ctl_b_r);
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("settings not latched");

  property p_storm;
    dest_mcast && !dest_all_ones && ctl_b_r[B_MC_STORM_DIS] |=> !storm_count;
  endproperty
  a_storm: assert property (p_storm) else $error("multicast counted");

  property p_pass_all;
    frame_done && pass_all |=> verdict_valid && !frame_drop;
  endproperty
  a_pass_all: assert property (p_pass_all) else $error("pass-all frame dropped");

  property p_vlan;
    frame_done && !pass_all && vlan_cross && snap_b_r[B_VLAN_DISCARD] |=> frame_drop;
  endproperty
  a_vlan: assert property (p_vlan) else $error("vlan crossing kept");

  property p_len;
    frame_done && !pass_all && snap_a_r[A_LEN_CHK] && len_type < LEN_TYPE_MAX
    && len_type != {5'h00, payload_len} |=> frame_drop;
  endproperty
  a_len: assert property (p_len) else $error("length mismatch kept");

  c_pass_bad: cover property (frame_done && frame_bad && pass_all ##1 !frame_drop);
  c_vlan_drop: cover property (frame_done && vlan_drop ##1 frame_drop);
  c_tick: cover property (age_tick && ag.fast);
endmodule : switch_global_frame_policy
`default_nettype wire

// ===== switch_global_frame_policy_tb.sv
`default_nettype none
module switch_global_frame_policy_tb
  import frame_policy_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk, rst, strap_pin_backoff_collision, strap_pin_max_length, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_rvalid, sniffer_active, frame_start, frame_done, frame_bad, frame_tagged;
  logic [10:0] frame_len, payload_len;
  logic [15:0] len_type;
  logic [4:0] collisions;
  logic vlan_cross, known_ucast, pause_req, rx_pause_frame, fc_contention;
  logic dest_all_ones, dest_mcast, mirror_req, verdict_valid, frame_drop, pause_send;
  logic pause_honor, drop_nonfc, throttle_fc, storm_count, mirror_allow, hub_mode;
  logic aggressive_backoff, carrier_backpressure, aging_on, age_tick;
  logic [5:0] hp_reserve;
  logic [7:0] sa, sb;
  logic [7:0] rd_q[$];
  logic vd_q[$];
  int errors = 0;
  int tests_run = 0;
  int seed = 5319;
  int n, i, k;

  // Short periods keep the aging checks inside the run budget
  switch_global_frame_policy #(.FAST_AGE_CYCLES(33'h14), .NORM_AGE_CYCLES(33'h32))
    switch_global_frame_policy_i (.clk, .rst, .strap_pin_backoff_collision,
    .strap_pin_max_length, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .reg_rvalid, .sniffer_active, .frame_start, .frame_done, .frame_bad, .frame_tagged,
    .frame_len, .len_type, .payload_len, .collisions, .vlan_cross, .known_ucast,
    .pause_req, .rx_pause_frame, .fc_contention, .dest_all_ones, .dest_mcast, .mirror_req,
    .verdict_valid, .frame_drop, .pause_send, .pause_honor, .drop_nonfc, .throttle_fc,
    .storm_count, .mirror_allow, .hub_mode, .aggressive_backoff, .carrier_backpressure,
    .aging_on, .age_tick, .hp_reserve);

  always #12.5 clk = ~clk;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    if (a == 8'h03) sa = d;
    if (a == 8'h04) sb = d;
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
  endtask : rd

  task automatic lv();
    @(negedge clk);
    chk("levels", 11'({sa[6], sa[0], sb[5], sa[2]}), 11'({hub_mode, aggressive_backoff,
      carrier_backpressure, aging_on}));
    chk("hp_reserve", sb[0] ? 11'h030 : 11'h000, 11'(hp_reserve));
  endtask : lv

  task automatic do_reset(input logic bc, input logic ml);
    strap_pin_backoff_collision = bc;
    strap_pin_max_length = ml;
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    sa = 8'h34 | {7'h00, bc};
    sb = 8'hf1 | {4'h0, bc, 1'b0, ml, 1'b0};
    rd(8'h03, sa);
    rd(8'h04, sb);
    wr(8'h07, 8'hff);
    rd(8'h07, 8'h00);
    rd(8'h04, sb);
    lv();
    $display("test reset done");
  endtask : do_reset

  task automatic ev(input int j);
    logic [5:0] e;
    e = 6'h00;
    case (j)
      0: e[0] = sa[5];
      1: e[1] = sa[4];
      2: e[3:2] = {~sb[4], sb[4]};
      3: e[4] = 1'b1;
      4: e[4] = ~sb[6];
      default: e[5] = sb[7];
    endcase
    {mirror_req, dest_mcast, dest_all_ones, fc_contention, rx_pause_frame, pause_req} =
      6'(1 << j);
    @(negedge clk);
    {mirror_req, dest_mcast, dest_all_ones, fc_contention, rx_pause_frame, pause_req} = 6'h00;
    chk("events", 11'(e), 11'({mirror_allow, storm_count, throttle_fc, drop_nonfc,
      pause_honor, pause_send}));
    @(negedge clk);
  endtask : ev

  function automatic logic drop_exp(input logic [7:0] a, input logic [7:0] b);
    logic [10:0] lim;
    lim = b[2] ? LEN_HUGE : !b[1] ? LEN_PLAIN : frame_tagged ? LEN_TAGGED : LEN_UNTAGGED;
    if (a[7] && sniffer_active) return 1'b0;
    return frame_bad || frame_len > lim
      || (a[3] && len_type < 16'h05dc && len_type != {5'h00, payload_len})
      || (!b[3] && collisions >= 5'h10)
      || (vlan_cross && (b[7] || !known_ucast));
  endfunction : drop_exp

  task automatic frame(input bit mid);
    logic [7:0] a, b;
    logic [10:0] lims[4];
    logic [31:0] x;
    lims = '{LEN_UNTAGGED, LEN_TAGGED, LEN_PLAIN, LEN_HUGE};
    x = $random(seed);
    {frame_tagged, sniffer_active, known_ucast} = x[2:0];
    frame_bad = &x[5:3];
    vlan_cross = &x[7:6];
    collisions = x[12:8];
    frame_len = lims[x[14:13]] + 11'(x[16:15]) - 11'h001;
    len_type = 16'h05d8 + 16'(x[19:17]);
    payload_len = len_type[10:0] + 11'(x[20] & x[21]);
    a = sa;
    b = sb;
    frame_start = 1'b1;
    @(negedge clk);
    frame_start = 1'b0;
    if (mid) begin
      wr(8'h03, ~a);
      wr(8'h04, ~b);
    end
    frame_done = 1'b1;
    vd_q.push_back(drop_exp(a, b));
    @(negedge clk);
    frame_done = 1'b0;
  endtask : frame

  task automatic gap(output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (age_tick !== 1'b1 && c < 120);
  endtask : gap

  // Results are paired with the oldest outstanding expectation
  always @(negedge clk) begin
    if (reg_rvalid === 1'b1) begin
      if (rd_q.size() == 0) chk("spurious rvalid", 11'h000, 11'h001);
      else chk("reg_rdata", 11'(rd_q.pop_front()), 11'(reg_rdata));
    end
    if (verdict_valid === 1'b1) begin
      if (vd_q.size() == 0) chk("spurious verdict", 11'h000, 11'h001);
      else chk("frame_drop", 11'(vd_q.pop_front()), 11'(frame_drop));
    end
  end

  initial begin
    repeat (60000) @(negedge clk);
    chk("timeout", 11'h000, 11'h001);
    end_of_test();
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {clk, reg_wr, reg_rd, frame_start, frame_done, reg_addr, reg_wdata} = '0;
    {frame_bad, frame_tagged, frame_len, len_type, payload_len, collisions} = '0;
    {vlan_cross, known_ucast, sniffer_active, pause_req, rx_pause_frame} = '0;
    {fc_contention, dest_all_ones, dest_mcast, mirror_req} = '0;
    do_reset(1'b1, 1'b0);
    for (i = 0; i < 4; i++) begin
      wr(8'h03, i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($random(seed)));
      wr(8'h04, i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($random(seed)));
      rd(8'h03, sa);
      rd(8'h04, sb);
      lv();
      for (k = 0; k < 6; k++) ev(k);
    end
    $display("test registers and events done");
    for (i = 0; i < 200; i++) begin
      if (i % 4 == 0) wr(8'h03, 8'($random(seed)));
      if (i % 4 == 0) wr(8'h04, 8'($random(seed)));
      frame(i % 25 == 24);
    end
    $display("test frames done");
    wr(8'h03, 8'h04);
    gap(n);
    gap(n);
    chk("normal age period", 11'h032, 11'(n));
    wr(8'h03, 8'h06);
    gap(n);
    gap(n);
    chk("fast age period", 11'h014, 11'(n));
    wr(8'h03, 8'h00);
    repeat (2) @(negedge clk);
    gap(n);
    chk("aging off", 11'h078, 11'(n));
    $display("test aging done");
    repeat (3) @(negedge clk);
    do_reset(1'b0, 1'b1);
    repeat (4) @(negedge clk);
    chk("pending results", 11'h000, 11'(rd_q.size() + vd_q.size()));
    end_of_test();
  end
endmodule : switch_global_frame_policy_tb
`default_nettype wire
